//--- hw/dsm_monitor.sv
// receive maintenance monitor: framing, alarms and status registers
// assumes line clock/data arrive asynchronously and are slower than i_clk_sys/4
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module dsm_monitor #(
  parameter int DS3_F_FIND  = 8,
  parameter int E3_FAS_FIND = 3,
  parameter int FMT_FRAMES  = 3,
  parameter int LOS_LIMIT   = dsm_pkg::LOS_NOMINAL
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_avs_address,
  input  wire logic       i_avs_read,
  input  wire logic       i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]     o_avs_readdata,
  output logic            o_avs_waitrequest,
  input  wire logic       i_line_clk,
  input  wire logic       i_line_data
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] dsm_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + 5'(v[i]);
    end
    return n;
  endfunction : dsm_ones

  typedef enum logic {DSM_HUNT, DSM_SYNC} dsm_state_t;

  // ----------------------------------------------------------------
  // line input synchronisers and bit strobe
  // ----------------------------------------------------------------
  logic       clk_s1;
  logic       clk_s2;
  logic       clk_s3;
  logic       dat_s1;
  logic       dat_s2;
  logic       bit_stb;
  logic       rx_bit;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      clk_s1 <= i_line_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= i_line_data;
      dat_s2 <= dat_s1;
    end
  end

  // data taken on the line clock rising edge as seen after the synchroniser
  assign bit_stb = clk_s2 & ~clk_s3;
  assign rx_bit  = dat_s2;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic       e3_mode;
  logic       e3_prev;
  logic       mode_chg;

  assign e3_mode  = ctrl[dsm_pkg::CTRL_E3_BIT];
  assign mode_chg = e3_mode ^ e3_prev;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      e3_prev <= 1'b0;
    end else begin
      e3_prev <= e3_mode;
    end
  end

  // ----------------------------------------------------------------
  // frame position
  // ----------------------------------------------------------------
  dsm_state_t  state;
  logic [10:0] bitc;
  logic [2:0]  blk;
  logic [2:0]  sub;
  logic [7:0]  good;
  logic        oof;
  logic [2:0]  mshift;
  logic [15:0] ferr_hist;
  logic [2:0]  mhist;
  logic        m_err_frame;
  logic [2:0]  fas_err_run;
  logic        fas_err_frame;

  logic        ds3_oh;
  logic        f_pos;
  logic        f_bad;
  logic        m_pos;
  logic        m_bad;
  logic        ds3_end;
  logic        e3_fas_pos;
  logic        fas_bad;
  logic        e3_end;
  logic        frame_end;
  logic [15:0] next_ferr;
  logic [2:0]  next_mhist;
  logic [10:0] next_bitc;
  logic [2:0]  next_blk;
  logic [2:0]  next_sub;

  always_comb begin
    ds3_oh     = (bitc == 11'h000);
    f_pos      = ds3_oh & blk[0];
    f_bad      = f_pos & (rx_bit != ((blk == 3'h1) || (blk == 3'h7)));
    m_pos      = ds3_oh & (blk == 3'h0) & (sub >= dsm_pkg::DS3_SUB_M1);
    m_bad      = m_pos & (rx_bit != (sub == dsm_pkg::DS3_SUB_M2));
    ds3_end    = (bitc == dsm_pkg::DS3_BLK_LAST) & (blk == dsm_pkg::DS3_BLK_MAX) & (sub == dsm_pkg::DS3_SUB_MAX);
    e3_fas_pos = (bitc <= dsm_pkg::E3_FAS_LAST);
    fas_bad    = e3_fas_pos & (rx_bit != dsm_pkg::E3_FAS[4'(4'h9 - bitc[3:0])]);
    e3_end     = (bitc == dsm_pkg::E3_FRAME_LAST);
    frame_end  = e3_mode ? e3_end : ds3_end;
    next_ferr  = {ferr_hist[14:0], f_bad};
    next_mhist = {mhist[1:0], m_err_frame | m_bad};
    next_bitc  = bitc + 11'h001;
    next_blk   = blk;
    next_sub   = sub;
    if (e3_mode) begin
      if (e3_end) begin
        next_bitc = 11'h000;
      end
    end else if (bitc == dsm_pkg::DS3_BLK_LAST) begin
      next_bitc = 11'h000;
      next_blk  = blk + 3'h1;
      if (blk == dsm_pkg::DS3_BLK_MAX) begin
        // a bad m pattern while hunting repeats subframe 7: one subframe slip
        if (sub == dsm_pkg::DS3_SUB_MAX) begin
          next_sub = (state == DSM_HUNT && {mshift[1:0], rx_bit} != dsm_pkg::DS3_M_PATTERN) ? sub : 3'h0;
        end else begin
          next_sub = sub + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state         <= DSM_HUNT;
      bitc          <= 11'h000;
      blk           <= 3'h0;
      sub           <= 3'h0;
      good          <= 8'h00;
      oof           <= 1'b0;
      mshift        <= 3'h0;
      ferr_hist     <= 16'h0000;
      mhist         <= 3'h0;
      m_err_frame   <= 1'b0;
      fas_err_run   <= 3'h0;
      fas_err_frame <= 1'b0;
    end else if (mode_chg) begin
      state     <= DSM_HUNT;
      bitc      <= 11'h000;
      blk       <= 3'h0;
      sub       <= 3'h0;
      good      <= 8'h00;
      ferr_hist <= 16'h0000;
      mhist     <= 3'h0;
    end else if (bit_stb) begin
      if (m_pos) begin
        mshift <= {mshift[1:0], rx_bit};
      end
      unique case (state)
        DSM_HUNT: begin
          if (e3_mode) begin
            if (fas_bad) begin
              // a one that breaks the word may still end a prefix of it; restarting at zero
              // would miss a word that follows a one, which a fixed payload never escapes
              good <= 8'h00;
              if (!rx_bit) begin
                bitc <= 11'h000;
              end else if (bitc == 11'h004) begin
                bitc <= 11'h004;
              end else if (bitc == 11'h006) begin
                bitc <= 11'h002;
              end else begin
                bitc <= 11'h001;
              end
            end else begin
              bitc <= next_bitc;
              if (bitc == dsm_pkg::E3_FAS_LAST) begin
                good <= good + 8'h01;
                if (good + 8'h01 >= 8'(E3_FAS_FIND)) begin
                  state         <= DSM_SYNC;
                  oof           <= 1'b0;
                  fas_err_run   <= 3'h0;
                  fas_err_frame <= 1'b0;
                end
              end
            end
          end else if (f_bad) begin
            // hold position: the next bit is tried in this slot
            good <= 8'h00;
          end else begin
            bitc <= next_bitc;
            blk  <= next_blk;
            sub  <= next_sub;
            if (f_pos && good < 8'hFF) begin
              good <= good + 8'h01;
            end
            if (ds3_end && good >= 8'(DS3_F_FIND) && {mshift[1:0], rx_bit} == dsm_pkg::DS3_M_PATTERN) begin
              state       <= DSM_SYNC;
              oof         <= 1'b0;
              ferr_hist   <= 16'h0000;
              mhist       <= 3'h0;
              m_err_frame <= 1'b0;
            end
          end
        end
        DSM_SYNC: begin
          bitc <= next_bitc;
          blk  <= next_blk;
          sub  <= next_sub;
          if (e3_mode) begin
            if (fas_bad) begin
              fas_err_frame <= 1'b1;
            end
            if (bitc == dsm_pkg::E3_FAS_LAST) begin
              fas_err_frame <= 1'b0;
              if (fas_bad || fas_err_frame) begin
                fas_err_run <= fas_err_run + 3'h1;
                if (fas_err_run + 3'h1 >= dsm_pkg::E3_FAS_ERR_LIM) begin
                  state <= DSM_HUNT;
                  oof   <= 1'b1;
                  good  <= 8'h00;
                  bitc  <= 11'h000;
                end
              end else begin
                fas_err_run <= 3'h0;
              end
            end
          end else begin
            if (f_pos) begin
              ferr_hist <= next_ferr;
            end
            if (m_bad) begin
              m_err_frame <= 1'b1;
            end
            if (ds3_end) begin
              mhist       <= next_mhist;
              m_err_frame <= 1'b0;
            end
            if ((f_pos && dsm_ones(next_ferr) >= 5'(dsm_pkg::DS3_F_ERR_LIM)) ||
                (ds3_end && dsm_ones({13'h0000, next_mhist}) >= 5'(dsm_pkg::DS3_M_ERR_LIM))) begin
              state <= DSM_HUNT;
              oof   <= 1'b1;
              good  <= 8'h00;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per m-frame overhead and payload checks (ds3), a-bit and ais (e3)
  // ----------------------------------------------------------------
  logic        par_acc;
  logic        prev_par;
  logic        par_ok;
  logic        c_all_zero;
  logic        c3_zero;
  logic        x1;
  logic        x2;
  logic        idle_ok;
  logic        ais_ok;
  logic        frm_err;
  logic [FMT_FRAMES-1:0] aic_hist;
  logic [1:0]  fmt;
  logic        idle_ds3;
  logic        ais_ds3;
  logic        yel_ds3;
  logic        a_bit;
  logic [10:0] ones_run;
  logic        ais_e3;
  logic [1:0]  pay_ph;

  assign pay_ph = 2'(bitc - 11'h001);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      par_acc    <= 1'b0;
      prev_par   <= 1'b0;
      par_ok     <= 1'b1;
      c_all_zero <= 1'b1;
      c3_zero    <= 1'b1;
      x1         <= 1'b1;
      x2         <= 1'b1;
      idle_ok    <= 1'b1;
      ais_ok     <= 1'b1;
      frm_err    <= 1'b0;
      aic_hist   <= '0;
      fmt        <= dsm_pkg::FMT_M13;
      idle_ds3   <= 1'b0;
      ais_ds3    <= 1'b0;
      yel_ds3    <= 1'b0;
      a_bit      <= 1'b0;
    end else if (state != DSM_SYNC || mode_chg) begin
      idle_ds3 <= 1'b0;
      ais_ds3  <= 1'b0;
      yel_ds3  <= 1'b0;
      a_bit    <= 1'b0;
      par_acc  <= 1'b0;
      par_ok   <= 1'b1;
      frm_err  <= 1'b0;
      idle_ok  <= 1'b1;
      ais_ok   <= 1'b1;
    end else if (bit_stb && e3_mode) begin
      if (bitc == dsm_pkg::E3_ABIT_POS) begin
        a_bit <= rx_bit;
      end
    end else if (bit_stb) begin
      if (!ds3_oh) begin
        par_acc <= par_acc ^ rx_bit;
        if (rx_bit != ~pay_ph[1]) begin
          idle_ok <= 1'b0;
        end
        if (rx_bit != ~pay_ph[0]) begin
          ais_ok <= 1'b0;
        end
      end else if (blk == 3'h0) begin
        if (sub == 3'h0) begin
          x1 <= rx_bit;
        end
        if (sub == 3'h1) begin
          x2 <= rx_bit;
        end
        if ((sub == dsm_pkg::DS3_SUB_P1 || sub == dsm_pkg::DS3_SUB_P2) && rx_bit != prev_par) begin
          par_ok <= 1'b0;
        end
      end else if (!blk[0]) begin
        if (rx_bit) begin
          c_all_zero <= 1'b0;
          if (sub == 3'h2) begin
            c3_zero <= 1'b0;
          end
        end
        if (sub == 3'h0 && blk == 3'h2) begin
          aic_hist <= {aic_hist[FMT_FRAMES-2:0], rx_bit};
        end
      end
      if (f_bad || m_bad) begin
        frm_err <= 1'b1;
      end
      if (ds3_end) begin
        // verdicts take effect for the following m-frame
        idle_ds3   <= par_ok & ~frm_err & ~m_bad & c3_zero & (x1 == x2) & idle_ok;
        ais_ds3    <= par_ok & ~frm_err & ~m_bad & c_all_zero & (x1 == x2) & ais_ok;
        yel_ds3    <= ~x1 & ~x2;
        prev_par   <= par_acc;
        par_acc    <= 1'b0;
        par_ok     <= 1'b1;
        c_all_zero <= 1'b1;
        c3_zero    <= 1'b1;
        idle_ok    <= 1'b1;
        ais_ok     <= 1'b1;
        frm_err    <= 1'b0;
        if (&aic_hist) begin
          fmt <= dsm_pkg::FMT_CBIT;
        end else if (~|aic_hist) begin
          fmt <= dsm_pkg::FMT_SYNTRAN;
        end else begin
          fmt <= dsm_pkg::FMT_M13;
        end
      end
    end
  end

  // unframed all ones: a full e3 frame length of ones while hunting
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ones_run <= 11'h000;
      ais_e3   <= 1'b0;
    end else if (bit_stb) begin
      if (!rx_bit || state == DSM_SYNC) begin
        ones_run <= 11'h000;
        ais_e3   <= 1'b0;
      end else if (ones_run == dsm_pkg::E3_FRAME_LAST) begin
        ais_e3 <= 1'b1;
      end else begin
        ones_run <= ones_run + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // loss of signal
  // ----------------------------------------------------------------
  logic [8:0] zero_run;
  logic       los;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      zero_run <= 9'h000;
      los      <= 1'b0;
    end else if (bit_stb) begin
      if (rx_bit) begin
        zero_run <= 9'h000;
        los      <= 1'b0;
      end else if (zero_run + 9'h001 >= 9'(LOS_LIMIT)) begin
        los <= 1'b1;
      end else begin
        zero_run <= zero_run + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // status, shadow and avalon slave
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] shadow;
  logic       ais_now;
  logic [7:0] next_status;
  logic       ack;
  logic       rd_shadow;

  always_comb begin
    ais_now                          = e3_mode ? ais_e3 : ais_ds3;
    next_status                      = 8'h00;
    next_status[dsm_pkg::ST_REFRAME] = (state == DSM_HUNT);
    next_status[dsm_pkg::ST_FMT_HI]  = ~e3_mode & fmt[1];
    next_status[dsm_pkg::ST_FMT_LO]  = ~e3_mode & fmt[0];
    next_status[dsm_pkg::ST_IDLE]    = ~e3_mode & idle_ds3;
    next_status[dsm_pkg::ST_REMOTE]  = ~(los | oof | ais_now) & (e3_mode ? a_bit : yel_ds3);
    next_status[dsm_pkg::ST_AIS]     = ais_now;
    next_status[dsm_pkg::ST_OOF]     = oof;
    next_status[dsm_pkg::ST_LOS]     = los;
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign rd_shadow         = ack & i_avs_read & (i_avs_address == dsm_pkg::SHADOW_ADDR);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      status <= dsm_pkg::STATUS_RESET;
      shadow <= dsm_pkg::STATUS_RESET;
    end else begin
      status <= next_status;
      // new indications win over the clear of the same read
      shadow <= (rd_shadow ? 8'h00 : shadow) | next_status;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack            <= 1'b0;
      ctrl           <= dsm_pkg::CTRL_RESET;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
      if (ack && i_avs_write && i_avs_address == dsm_pkg::CTRL_ADDR) begin
        ctrl <= i_avs_writedata[7:0];
      end
      if ((i_avs_read | i_avs_write) && !ack) begin
        unique case (i_avs_address)
          dsm_pkg::CTRL_ADDR:   o_avs_readdata <= {24'h000000, ctrl};
          dsm_pkg::STATUS_ADDR: o_avs_readdata <= {24'h000000, status};
          dsm_pkg::SHADOW_ADDR: o_avs_readdata <= {24'h000000, shadow};
          default:              o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : dsm_monitor

//--- hw/dsm_pkg.sv
// constants for the ds3/e3 receive maintenance monitor
// assumes one 100 MHz system clock and a sampled line clock of a few MHz
package dsm_pkg;
  // ----------------------------------------------------------------
  // register map (printed indices, byte address is four times index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX         = 8'h00;
  localparam logic [7:0] STATUS_IDX       = 8'h10;
  localparam logic [7:0] SHADOW_IDX       = 8'h16;
  localparam logic [7:0] CTRL_ADDR        = 8'(CTRL_IDX * 4);
  localparam logic [7:0] STATUS_ADDR      = 8'(STATUS_IDX * 4);
  localparam logic [7:0] SHADOW_ADDR      = 8'(SHADOW_IDX * 4);
  localparam int         CTRL_E3_BIT      = 0;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] STATUS_RESET     = 8'h00;

  // status bit positions
  localparam int         ST_REFRAME       = 7;
  localparam int         ST_FMT_HI        = 6;
  localparam int         ST_FMT_LO        = 5;
  localparam int         ST_IDLE          = 4;
  localparam int         ST_REMOTE        = 3;
  localparam int         ST_AIS           = 2;
  localparam int         ST_OOF           = 1;
  localparam int         ST_LOS           = 0;

  // format codes
  localparam logic [1:0] FMT_M13          = 2'h0;
  localparam logic [1:0] FMT_CBIT         = 2'h1;
  localparam logic [1:0] FMT_SYNTRAN      = 2'h2;

  // ----------------------------------------------------------------
  // ds3 frame geometry and alignment
  // ----------------------------------------------------------------
  localparam logic [10:0] DS3_BLK_LAST    = 11'h054;
  localparam logic [2:0]  DS3_BLK_MAX     = 3'h7;
  localparam logic [2:0]  DS3_SUB_MAX     = 3'h6;
  localparam logic [2:0]  DS3_SUB_P1      = 3'h2;
  localparam logic [2:0]  DS3_SUB_P2      = 3'h3;
  localparam logic [2:0]  DS3_SUB_M1      = 3'h4;
  localparam logic [2:0]  DS3_SUB_M2      = 3'h5;
  localparam logic [2:0]  DS3_M_PATTERN   = 3'h2;
  localparam int          DS3_F_WIN       = 16;
  localparam int          DS3_F_ERR_LIM   = 3;
  localparam int          DS3_M_ERR_LIM   = 2;

  // ----------------------------------------------------------------
  // e3 frame geometry
  // ----------------------------------------------------------------
  localparam logic [10:0] E3_FRAME_LAST   = 11'h5FF;
  localparam logic [10:0] E3_FAS_LAST     = 11'h009;
  localparam logic [10:0] E3_ABIT_POS     = 11'h00A;
  localparam logic [9:0]  E3_FAS          = 10'h3D0;
  localparam logic [2:0]  E3_FAS_ERR_LIM  = 3'h4;

  // ----------------------------------------------------------------
  // loss of signal, in line bit periods
  // ----------------------------------------------------------------
  localparam int          LOS_NOMINAL     = 175;
  localparam int          LOS_TOLERANCE   = 75;
endpackage : dsm_pkg

//--- testbench/dsm_line_src.sv
// remote transmitter: steady ones, steady zeros or framed e3 stream
// assumes mode changes are taken at the next bit boundary
`timescale 1ns/100ps
module dsm_line_src (
  input  wire logic [1:0] i_mode,
  input  wire logic       i_abit,
  output logic            o_line_clk,
  output logic            o_line_data
);
  int pos;
  // ----
  // bit generator; data moves on the falling line edge, 125 ns bits
  // ----
  initial begin
    o_line_clk  = 1'b0;
    o_line_data = 1'b1;
    pos         = 0;
    forever begin
      #62.5 o_line_clk = 1'b1;
      #62.5 o_line_clk = 1'b0;
      pos = (pos + 1) % 1536;
      case (i_mode)
        2'h0: o_line_data = 1'b1;
        2'h1: o_line_data = 1'b0;
        // payload alternates so it can never mimic the alignment word
        default: o_line_data = pos < 10 ? dsm_pkg::E3_FAS[9 - pos] : (pos == 10 ? i_abit : pos[0]);
      endcase
    end
  end
endmodule : dsm_line_src

//--- testbench/dsm_monitor_chk.sv
// checker for the monitor's bus answers and status relations
// assumes binding to dsm_monitor; one clock domain, async reset
`timescale 1ns/100ps
module dsm_monitor_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_line_clk,
  input wire logic        i_line_data
);
  logic       e3_mode;
  logic       rd_done;
  logic       st_rd;
  logic [7:0] st;
  // ----
  // mode as last written by the host
  // ----
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      e3_mode <= 1'b0;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00) begin
      e3_mode <= i_avs_writedata[0];
    end
  end
  assign rd_done = i_avs_read && !o_avs_waitrequest;
  assign st_rd   = rd_done && i_avs_address == 8'h40;
  assign st      = o_avs_readdata[7:0];
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  a_one_wait_state: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait state");
  a_idle_no_wait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest high with no request");
  a_upper_zero: assert property (rd_done |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (rd_done && !(i_avs_address inside {8'h00, 8'h40, 8'h58}) |-> st == 8'h00)
    else $error("unmapped read not zero");
  a_e3_idle_low: assert property (st_rd && e3_mode |-> !st[4])
    else $error("idle seen in e3 mode");
  a_e3_format_zero: assert property (st_rd && e3_mode |-> st[6:5] == 2'h0)
    else $error("format code set in e3 mode");
  a_yellow_masked: assert property (st_rd && (st[0] || st[1] || st[2]) |-> !st[3])
    else $error("yellow shown beside a stronger alarm");
  a_oof_reframe: assert property (st_rd && st[1] |-> st[7])
    else $error("out of frame without reframe");
  c_los_read: cover property (st_rd && st[0]);
  c_ais_read: cover property (st_rd && st[2]);
  c_yellow_read: cover property (st_rd && st[3]);
endmodule : dsm_monitor_chk
bind dsm_monitor dsm_monitor_chk dsm_monitor_chk_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_line_clk(i_line_clk), .i_line_data(i_line_data));

//--- testbench/dsm_monitor_tb.sv
// self-checking bench: register access, loss of signal and e3 alarms
// assumes dsm_line_src as the remote transmitter and default parameters
`timescale 1ns/100ps
module dsm_monitor_tb;
  typedef struct packed {logic wr; logic [7:0] wa; logic [31:0] wd;
                         logic [7:0] ra; logic [31:0] mask; logic [31:0] exp;} dsm_row_t;
  logic        i_clk_sys, line_clk, line_data, o_avs_waitrequest;
  logic        i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0, abit = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  int          err_total = 0, compares = 0, cycles = 0;
  dsm_row_t    rows [6] = '{
    '{1'b0, 8'h00, 32'h0, 8'h00, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h00, 32'h1, 8'h00, 32'hFFFFFFFF, 32'h1},
    '{1'b1, 8'h00, 32'h0, 8'h00, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h40, 32'hFF, 8'h04, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h7C, 32'hA5, 8'h7C, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 8'h00, 32'h0, 8'h40, 32'hFFFFFF9D, 32'h80}};
  dsm_monitor dsm_monitor_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_line_clk(line_clk), .i_line_data(line_data));
  dsm_line_src dsm_line_src_inst (.i_mode(mode), .i_abit(abit), .o_line_clk(line_clk), .o_line_data(line_data));
  // ----
  // reporting and bus tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // waitrequest and read data are taken at the rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    do begin
      @(posedge i_clk_sys);
      w = o_avs_waitrequest;
      q = o_avs_readdata;
    end while (w !== 1'b0);
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    @(posedge i_clk_sys);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q & m, e);
  endtask : rd
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        bus(1'b1, rows[i].wa, rows[i].wd);
      end
      bus(1'b0, rows[i].ra, 32'h0);
      check(q & rows[i].mask, rows[i].exp);
    end
    mode <= 2'h1;
    repeat (1175) @(posedge i_clk_sys);
    rd(8'h40, 32'h1, 32'h0);
    repeat (2100) @(posedge i_clk_sys);
    rd(8'h40, 32'h9, 32'h1);
    mode <= 2'h0;
    repeat (60) @(posedge i_clk_sys);
    rd(8'h58, 32'h1, 32'h1);
    rd(8'h58, 32'h1, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    repeat (20200) @(posedge i_clk_sys);
    rd(8'h40, 32'hFFFFFFFC, 32'h84);
    mode <= 2'h2;
    // poll bounded at 60 reads; a hunt that never ends leaves the loop and fails the final read
    for (int i = 0; i < 60 && q[7] !== 1'b0; i++) begin
      repeat (1000) @(posedge i_clk_sys);
      bus(1'b0, 8'h40, 32'h0);
    end
    repeat (200) @(posedge i_clk_sys);
    rd(8'h40, 32'hFFFFFFFF, 32'h08);
    wrap_up();
  end
endmodule : dsm_monitor_tb
